// File: core/ptsp_defs.svh
// Register indices, reset values and widths for the port pin control block.
`ifndef PTSP_DEFS_SVH
`define PTSP_DEFS_SVH

// ==========================================================================
// Widths
`define PTSP_TW        8
`define PTSP_SW        4
`define PTSP_ROUTE_W   5
`define PTSP_IDX_W     6
`define PTSP_IDX_LSB   2

// ==========================================================================
// Register indices; the byte address is four times the index.
`define PTSP_IDX_TDATA 6'h00
`define PTSP_IDX_TIN   6'h01
`define PTSP_IDX_TDIR  6'h02
`define PTSP_IDX_TPE   6'h04
`define PTSP_IDX_TPOL  6'h05
`define PTSP_IDX_ROUTE 6'h07
`define PTSP_IDX_SDATA 6'h08
`define PTSP_IDX_SIN   6'h09
`define PTSP_IDX_SDIR  6'h0A
`define PTSP_IDX_SRDR  6'h0B
`define PTSP_IDX_SPE   6'h0C
`define PTSP_IDX_SPOL  6'h0D
`define PTSP_IDX_SWOM  6'h0E

// ==========================================================================
// Reset values
`define PTSP_RST_T8    8'h00
`define PTSP_RST_S4    4'h0
`define PTSP_RST_SPE   4'hF
`define PTSP_RST_ROUTE 5'h00

`endif

// File: core/ptsp_pkg.sv
// Types shared by the port pin control block.
package ptsp_pkg;

	// ======================================================================
	// Pad control carriers
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull_en;
		logic [7:0] pull_dn;
	} ptsp_tpad_s;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
		logic [3:0] pull_en;
		logic [3:0] pull_dn;
		logic [3:0] reduced;
	} ptsp_spad_s;

	// ======================================================================
	// Bus slave states
	typedef enum logic {
		BUS_IDLE,
		BUS_READ
	} ptsp_bus_e;

endpackage : ptsp_pkg

// File: core/ptsp_sync.sv
// Two-flop synchroniser for pin levels.
`timescale 1ns/1ps
module ptsp_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : ptsp_sync

// File: core/ptsp_top.sv
// Timer port and serial port pin control with an AHB-Lite register slave.
// Function
// - Timer polarity picks pull, only on inputs
// - Routing bit 0 timer, 1 PWM
// - PWM, then timer, then general I/O
// - Data read: latch if direction bit is 1, else pin
// - Transmit forces pin 1 out, receive pin 0 in
// - Readback shows pin levels, ignores writes
// - Direction bit 0 input, 1 output
// - Enabled serial channel overrides direction bit
// - Reads settle within 2 cycles via synchronisers
// - Reduced drive bit ignored on inputs
// - Pull only on inputs or wired-OR, reset pull-up
// - Wired-OR pins drive low only
`timescale 1ns/1ps
`include "ptsp_defs.svh"
module ptsp_top
	import ptsp_pkg::*;
#(
	parameter int ROUTE_W = `PTSP_ROUTE_W
) (
	// Clock and reset
	input  wire logic               CLK,
	input  wire logic               NRST,
	// AHB-Lite slave
	input  wire logic               HSEL,
	input  wire logic [31:0]        HADDR,
	input  wire logic [1:0]         HTRANS,
	input  wire logic               HWRITE,
	input  wire logic [2:0]         HSIZE,
	input  wire logic [31:0]        HWDATA,
	input  wire logic               HREADY,
	output logic                    HREADYOUT,
	output logic                    HRESP,
	output logic      [31:0]        HRDATA,
	// Timer and PWM units
	input  wire logic [7:0]         TIM_OUT_EN,
	input  wire logic [7:0]         TIM_OUT,
	output logic      [7:0]         TIM_IN,
	input  wire logic [ROUTE_W-1:0] PWM_EN,
	input  wire logic [ROUTE_W-1:0] PWM_OUT,
	// Serial unit
	input  wire logic               SER_TX_EN,
	input  wire logic               SER_RX_EN,
	input  wire logic               SER_TXD,
	output logic                    SER_RXD,
	// Pads
	input  wire logic [7:0]         PT_IN,
	output ptsp_tpad_s              PT_PAD,
	input  wire logic [3:0]         PS_IN,
	output ptsp_spad_s              PS_PAD
);

	// ======================================================================
	// Declarations
	logic [7:0]           tdata_r, tdir_r, tpe_r, tpol_r;
	logic [ROUTE_W-1:0]   route_r;
	logic [3:0]           sdata_r, sdir_r, srdr_r, spe_r, spol_r, swom_r;
	ptsp_bus_e            bus_st_r;
	logic [5:0]           idx_r;
	logic [7:0]           t_sync, t_oe_nxt, t_val_nxt, wb;
	logic [3:0]           s_sync, s_oe_nxt, s_val_nxt;
	logic [31:0]          rd_nxt;
	logic                 wr_pend_r, acc, wr_hit;

	function automatic logic is_mapped(input logic [5:0] idx);
		case (idx)
			`PTSP_IDX_TDATA, `PTSP_IDX_TIN, `PTSP_IDX_TDIR,
			`PTSP_IDX_TPE, `PTSP_IDX_TPOL, `PTSP_IDX_ROUTE,
			`PTSP_IDX_SDATA, `PTSP_IDX_SIN, `PTSP_IDX_SDIR,
			`PTSP_IDX_SRDR, `PTSP_IDX_SPE, `PTSP_IDX_SPOL,
			`PTSP_IDX_SWOM: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : is_mapped

	// ======================================================================
	// Pin synchronisers
	// Two-stage pin sampling
	ptsp_sync #(.W(8)) u_tsync (
		.clk  (CLK),
		.nrst (NRST),
		.d    (PT_IN),
		.q    (t_sync)
	);

	ptsp_sync #(.W(4)) u_ssync (
		.clk  (CLK),
		.nrst (NRST),
		.d    (PS_IN),
		.q    (s_sync)
	);

	// The timer capture inputs and serial receiver see the pins always.
	assign TIM_IN  = t_sync;
	assign SER_RXD = s_sync[0];

	// ======================================================================
	// Bus slave
	// Reads take one wait state so a write in the preceding data phase
	// has landed before the read data is sampled.
	assign acc    = HSEL && HTRANS[1] && HREADY;
	assign wr_hit = wr_pend_r && is_mapped(idx_r);
	assign wb     = HWDATA[7:0];

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			bus_st_r  <= BUS_IDLE;
			wr_pend_r <= 1'b0;
			idx_r     <= 6'h00;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
			HRDATA    <= 32'h0000_0000;
		end
		else
		begin
			case (bus_st_r)
				BUS_IDLE:
				begin
					wr_pend_r <= acc && HWRITE;
					if (acc)
					begin
						idx_r <= HADDR[7:2];
					end
					if (acc && !HWRITE)
					begin
						HREADYOUT <= 1'b0;
						bus_st_r  <= BUS_READ;
					end
				end
				BUS_READ:
				begin
					wr_pend_r <= 1'b0;
					HRDATA    <= rd_nxt;
					HREADYOUT <= 1'b1;
					bus_st_r  <= BUS_IDLE;
				end
				default:
				begin
					bus_st_r  <= BUS_IDLE;
					HREADYOUT <= 1'b1;
				end
			endcase
		end
	end

	// ======================================================================
	// Read data
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		case (idx_r)
			`PTSP_IDX_TDATA: rd_nxt[7:0] = (tdir_r & tdata_r) |
				(~tdir_r & t_sync);
			`PTSP_IDX_TIN:   rd_nxt[7:0] = t_sync;
			`PTSP_IDX_TDIR:  rd_nxt[7:0] = tdir_r;
			`PTSP_IDX_TPE:   rd_nxt[7:0] = tpe_r;
			`PTSP_IDX_TPOL:  rd_nxt[7:0] = tpol_r;
			`PTSP_IDX_ROUTE: rd_nxt[ROUTE_W-1:0] = route_r;
			`PTSP_IDX_SDATA: rd_nxt[3:0] = (sdir_r & sdata_r) |
				(~sdir_r & s_sync);
			`PTSP_IDX_SIN:   rd_nxt[3:0] = s_sync;
			`PTSP_IDX_SDIR:  rd_nxt[3:0] = sdir_r;
			`PTSP_IDX_SRDR:  rd_nxt[3:0] = srdr_r;
			`PTSP_IDX_SPE:   rd_nxt[3:0] = spe_r;
			`PTSP_IDX_SPOL:  rd_nxt[3:0] = spol_r;
			`PTSP_IDX_SWOM:  rd_nxt[3:0] = swom_r;
			default:         rd_nxt = 32'h0000_0000;
		endcase
	end

	// ======================================================================
	// Timer port registers
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			tdata_r <= `PTSP_RST_T8;
			tdir_r  <= `PTSP_RST_T8;
			tpe_r   <= `PTSP_RST_T8;
			tpol_r  <= `PTSP_RST_T8;
			route_r <= ROUTE_W'(`PTSP_RST_ROUTE);
		end
		else if (wr_hit)
		begin
			case (idx_r)
				`PTSP_IDX_TDATA: tdata_r <= wb;
				`PTSP_IDX_TDIR:  tdir_r  <= wb;
				`PTSP_IDX_TPE:   tpe_r   <= wb;
				`PTSP_IDX_TPOL:  tpol_r  <= wb;
				// Bit 4 is writable and routes pin 4 to PWM
				`PTSP_IDX_ROUTE: route_r <= wb[ROUTE_W-1:0];
				default:         tdata_r <= tdata_r;
			endcase
		end
	end

	// ======================================================================
	// Serial port registers
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			sdata_r <= `PTSP_RST_S4;
			sdir_r  <= `PTSP_RST_S4;
			srdr_r  <= `PTSP_RST_S4;
			spe_r   <= `PTSP_RST_SPE;
			spol_r  <= `PTSP_RST_S4;
			swom_r  <= `PTSP_RST_S4;
		end
		else if (wr_hit)
		begin
			case (idx_r)
				`PTSP_IDX_SDATA: sdata_r <= wb[3:0];
				`PTSP_IDX_SDIR:  sdir_r  <= wb[3:0];
				`PTSP_IDX_SRDR:  srdr_r  <= wb[3:0];
				`PTSP_IDX_SPE:   spe_r   <= wb[3:0];
				`PTSP_IDX_SPOL:  spol_r  <= wb[3:0];
				`PTSP_IDX_SWOM:  swom_r  <= wb[3:0];
				default:         sdata_r <= sdata_r;
			endcase
		end
	end

	// ======================================================================
	// Timer port pin source selection
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_tpin
			if (gi < ROUTE_W)
			begin : g_routed
				logic pwm_sel;
				assign pwm_sel = route_r[gi] && PWM_EN[gi];
				assign t_oe_nxt[gi]  = pwm_sel || TIM_OUT_EN[gi] ||
					tdir_r[gi];
				assign t_val_nxt[gi] = pwm_sel ? PWM_OUT[gi] :
					TIM_OUT_EN[gi] ? TIM_OUT[gi] : tdata_r[gi];
			end
			else
			begin : g_plain
				assign t_oe_nxt[gi]  = TIM_OUT_EN[gi] || tdir_r[gi];
				assign t_val_nxt[gi] = TIM_OUT_EN[gi] ? TIM_OUT[gi] :
					tdata_r[gi];
			end
		end
	endgenerate

	// ======================================================================
	// Serial port pin direction
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_spin
			if (gi == 1)
			begin : g_tx
				assign s_oe_nxt[gi]  = SER_TX_EN || sdir_r[gi];
				assign s_val_nxt[gi] = SER_TX_EN ? SER_TXD : sdata_r[gi];
			end
			else if (gi == 0)
			begin : g_rx
				assign s_oe_nxt[gi]  = !SER_RX_EN && sdir_r[gi];
				assign s_val_nxt[gi] = sdata_r[gi];
			end
			else
			begin : g_gpio
				assign s_oe_nxt[gi]  = sdir_r[gi];
				assign s_val_nxt[gi] = sdata_r[gi];
			end
		end
	endgenerate

	// ======================================================================
	// Pad registers
	// Pad controls are registered so every pin output is glitch free.
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			PT_PAD <= '0;
			PS_PAD <= '0;
		end
		else
		begin
			PT_PAD.out     <= t_val_nxt;
			PT_PAD.oe      <= t_oe_nxt;
			PT_PAD.pull_en <= tpe_r & ~t_oe_nxt;
			PT_PAD.pull_dn <= tpol_r;
			PS_PAD.out     <= s_val_nxt & ~swom_r;
			PS_PAD.oe      <= s_oe_nxt & ~(swom_r & s_val_nxt);
			PS_PAD.pull_en <= spe_r & (~s_oe_nxt | swom_r);
			PS_PAD.pull_dn <= spol_r;
			PS_PAD.reduced <= srdr_r & s_oe_nxt;
		end
	end

	// ======================================================================
	// Assertions
	a_tpull_input: assert property (@(posedge CLK) disable iff (!NRST)
		(PT_PAD.pull_en & PT_PAD.oe) == 8'h00)
		else $error("Timer pull enabled on a driven pin.");
	a_tpull_pol: assert property (@(posedge CLK) disable iff (!NRST)
		PT_PAD.pull_dn == $past(tpol_r))
		else $error("Timer pull polarity does not follow register.");
	a_route_pwm: assert property (@(posedge CLK) disable iff (!NRST)
		(route_r[0] && PWM_EN[0]) |=>
		(PT_PAD.oe[0] && PT_PAD.out[0] == $past(PWM_OUT[0])))
		else $error("Routed pin 0 not driven by PWM.");
	a_route_timer: assert property (@(posedge CLK) disable iff (!NRST)
		(!route_r[0] && TIM_OUT_EN[0]) |=>
		(PT_PAD.oe[0] && PT_PAD.out[0] == $past(TIM_OUT[0])))
		else $error("Pin 0 not driven by timer.");
	a_sdata_read: assert property (@(posedge CLK) disable iff (!NRST)
		(bus_st_r == BUS_READ && idx_r == `PTSP_IDX_SDATA) |=>
		HRDATA[3:0] == ($past(sdir_r & sdata_r) | $past(~sdir_r & s_sync)))
		else $error("Serial data read mixes latch and pin wrongly.");
	a_tx_force: assert property (@(posedge CLK) disable iff (!NRST)
		(SER_TX_EN && !swom_r[1]) |=> PS_PAD.oe[1])
		else $error("Transmit pin not forced to output.");
	a_rx_force: assert property (@(posedge CLK) disable iff (!NRST)
		SER_RX_EN |=> !PS_PAD.oe[0])
		else $error("Receive pin not forced to input.");
	a_readback: assert property (@(posedge CLK) disable iff (!NRST)
		(bus_st_r == BUS_READ && idx_r == `PTSP_IDX_SIN) |=>
		HRDATA == {28'h0000000, $past(s_sync)})
		else $error("Readback does not show pin levels.");
	a_dir_gpio: assert property (@(posedge CLK) disable iff (!NRST)
		!swom_r[2] |=> PS_PAD.oe[2] == $past(sdir_r[2]))
		else $error("Pin 2 direction does not follow register.");
	a_sync_delay: assert property (@(posedge CLK) disable iff (!NRST)
		NRST && $past(NRST, 2) |-> s_sync == $past(PS_IN, 2))
		else $error("Pin sampling latency is not two cycles.");
	a_reduced_in: assert property (@(posedge CLK) disable iff (!NRST)
		(PS_PAD.reduced & ~$past(s_oe_nxt)) == 4'h0)
		else $error("Reduced drive active on an input.");
	a_spull_pp: assert property (@(posedge CLK) disable iff (!NRST)
		(PS_PAD.pull_en & $past(s_oe_nxt & ~swom_r)) == 4'h0)
		else $error("Pull enabled on a push-pull output.");
	a_wom_low: assert property (@(posedge CLK) disable iff (!NRST)
		(PS_PAD.oe & $past(swom_r) & PS_PAD.out) == 4'h0)
		else $error("Wired-OR pin drives high.");
	a_read_wait: assert property (@(posedge CLK) disable iff (!NRST)
		!HREADYOUT |=> HREADYOUT)
		else $error("Read wait longer than one cycle.");
	c_pwm_route: cover property (@(posedge CLK) disable iff (!NRST)
		route_r[0] && PWM_EN[0]);
	c_tx_on: cover property (@(posedge CLK) disable iff (!NRST)
		SER_TX_EN && !sdir_r[1]);
	c_sdata_rd: cover property (@(posedge CLK) disable iff (!NRST)
		bus_st_r == BUS_READ && idx_r == `PTSP_IDX_SDATA);
	c_wom_low: cover property (@(posedge CLK) disable iff (!NRST)
		|(PS_PAD.oe & ~PS_PAD.out & PS_PAD.pull_en));

endmodule : ptsp_top

// File: tb/ptsp_pins_model.sv
// External pin model: resolves every pad from block drive, pulls, and outside drive on the serial pins only.
`timescale 1ns/1ps
module ptsp_pins_model
	import ptsp_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Pads from the block
	input  ptsp_tpad_s      pt_pad,
	input  ptsp_spad_s      ps_pad,
	// Outside drivers on the serial pins
	input  wire logic [3:0] ext_en,
	input  wire logic [3:0] ext_val,
	// Pin levels seen by the block
	output logic      [7:0] pt_in,
	output logic      [3:0] ps_in
);
	// A pin nobody drives or pulls toggles, so a stale level never passes.
	logic float_r = 1'b0;

	always_ff @(posedge clk)
		float_r <= ~float_r;

	always_comb
	begin
		for (int i = 0; i < 8; i++)
			pt_in[i] = pt_pad.oe[i] ? pt_pad.out[i] :
				pt_pad.pull_en[i] ? ~pt_pad.pull_dn[i] : float_r;
		for (int i = 0; i < 4; i++)
			ps_in[i] = ps_pad.oe[i] ? ps_pad.out[i] :
				ext_en[i] ? ext_val[i] :
				ps_pad.pull_en[i] ? ~ps_pad.pull_dn[i] : float_r;
	end
endmodule : ptsp_pins_model

// File: tb/port_t_s_pin_control_test.sv
// Self-checking bench for the timer and serial port pin control block.
`timescale 1ns/1ps
module port_t_s_pin_control_test import ptsp_pkg::*;;
	logic        CLK = 1'b0;
	logic        NRST, HSEL, HWRITE, HREADYOUT, HRESP;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0]  HTRANS;
	logic [2:0]  HSIZE;
	logic [7:0]  TIM_OUT_EN, TIM_OUT, TIM_IN, PT_IN;
	logic [4:0]  PWM_EN, PWM_OUT;
	logic        SER_TX_EN, SER_RX_EN, SER_TXD, SER_RXD;
	logic [3:0]  PS_IN, ext_en, ext_val;
	ptsp_tpad_s  PT_PAD;
	ptsp_spad_s  PS_PAD;
	int          fail_count = 0;
	int          n_checks = 0;

	always #4 CLK = ~CLK;

	ptsp_top uut (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.HRDATA(HRDATA), .TIM_OUT_EN(TIM_OUT_EN), .TIM_OUT(TIM_OUT),
		.TIM_IN(TIM_IN), .PWM_EN(PWM_EN), .PWM_OUT(PWM_OUT),
		.SER_TX_EN(SER_TX_EN), .SER_RX_EN(SER_RX_EN), .SER_TXD(SER_TXD),
		.SER_RXD(SER_RXD), .PT_IN(PT_IN), .PT_PAD(PT_PAD), .PS_IN(PS_IN),
		.PS_PAD(PS_PAD));

	ptsp_pins_model pins (.clk(CLK), .pt_pad(PT_PAD), .ps_pad(PS_PAD),
		.ext_en(ext_en), .ext_val(ext_val), .pt_in(PT_IN), .ps_in(PS_IN));

	// ==========
	// Reporting and bus tasks
	task summarize;
		$display("Checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 20);
		if (HREADYOUT !== 1'b1)
		begin
			fail_count++;
			summarize();
		end
	endtask : wait_ready

	task bus(input logic w, input logic [5:0] ix, input logic [7:0] v,
		output logic [31:0] d);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, ix, 2'h0};
		wait_ready();
		HTRANS <= 2'h0;
		HWDATA <= {24'h0, v};
		wait_ready();
		d = HRDATA;
		HSEL <= 1'b0;
	endtask : bus

	task wr(input logic [5:0] ix, input logic [7:0] v);
		logic [31:0] d;
		bus(1'b1, ix, v, d);
	endtask : wr

	task rc(input string nm, input logic [5:0] ix, input logic [31:0] ex);
		logic [31:0] d;
		bus(1'b0, ix, 8'h00, d);
		chk(nm, ex, d);
		chk("hresp", 32'h0, HRESP);
	endtask : rc

	// Covers the pad register plus the two synchroniser flops.
	task settle;
		repeat (4) @(posedge CLK);
	endtask : settle

	// ==========
	// Scenarios
	task t_reset;
		rc("tpol", 6'h05, 32'h0);
		rc("route", 6'h07, 32'h0);
		rc("sdir", 6'h0A, 32'h0);
		rc("srdr", 6'h0B, 32'h0);
		rc("spe", 6'h0C, 32'hF);
		chk("ps_pull_en", 32'hF, PS_PAD.pull_en);
		chk("ps_pull_dn", 32'h0, PS_PAD.pull_dn);
	endtask : t_reset

	task t_tpull;
		wr(6'h04, 8'hFF);
		wr(6'h05, 8'hA5);
		wr(6'h02, 8'h0F);
		settle();
		rc("tpol", 6'h05, 32'hA5);
		chk("pt_pull_en", 32'hF0, PT_PAD.pull_en);
		chk("pt_pull_dn", 32'hA0, PT_PAD.pull_dn & PT_PAD.pull_en);
		chk("tim_in", 32'h50, TIM_IN);
		rc("tdata_pin", 6'h00, 32'h50);
		rc("tin", 6'h01, 32'h50);
	endtask : t_tpull

	task t_route;
		wr(6'h02, 8'hFF);
		wr(6'h00, 8'hC0);
		@(posedge CLK);
		TIM_OUT_EN <= 8'h0F;
		TIM_OUT <= 8'h05;
		PWM_EN <= 5'h15;
		PWM_OUT <= 5'h1A;
		wr(6'h07, 8'h13);
		settle();
		chk("pt_oe", 32'hFF, PT_PAD.oe);
		chk("pt_out_pwm", 32'hD4, PT_PAD.out);
		wr(6'h07, 8'h00);
		settle();
		chk("pt_out_tim", 32'hC5, PT_PAD.out);
	endtask : t_route

	task t_sdata;
		@(posedge CLK);
		ext_en <= 4'hA;
		ext_val <= 4'h8;
		wr(6'h0A, 8'h05);
		wr(6'h08, 8'h03);
		settle();
		chk("ps_oe", 32'h5, PS_PAD.oe);
		rc("sdata", 6'h08, 32'h9);
		rc("sin", 6'h09, 32'h9);
		wr(6'h09, 8'hFF);
		wr(6'h3F, 8'hFF);
		rc("sin_wr", 6'h09, 32'h9);
		rc("unmapped", 6'h3F, 32'h0);
		wr(6'h0A, 8'h00);
		settle();
		rc("sdata_in", 6'h08, 32'hD);
	endtask : t_sdata

	// The outside drives pin 0 low against a latched one, so only a
	// receiver that really releases the pin shows a low level.
	task t_serial;
		@(posedge CLK);
		ext_en <= 4'h1;
		ext_val <= 4'h0;
		wr(6'h0A, 8'h01);
		wr(6'h0B, 8'h0F);
		settle();
		chk("rd_out", 32'h1, PS_PAD.reduced);
		SER_TX_EN <= 1'b1;
		SER_RX_EN <= 1'b1;
		SER_TXD <= 1'b1;
		settle();
		chk("ps_oe_ser", 32'h2, PS_PAD.oe);
		chk("ps_txd", 32'h2, PS_PAD.out & PS_PAD.oe);
		chk("rd_ser", 32'h2, PS_PAD.reduced);
		chk("rxd", 32'h0, SER_RXD);
		wr(6'h0A, 8'h00);
		settle();
		chk("ps_oe_hold", 32'h2, PS_PAD.oe);
		SER_TX_EN <= 1'b0;
		SER_RX_EN <= 1'b0;
		settle();
		chk("ps_oe_back", 32'h0, PS_PAD.oe);
	endtask : t_serial

	task t_wor;
		@(posedge CLK);
		ext_en <= 4'h0;
		wr(6'h0A, 8'h03);
		wr(6'h0E, 8'h01);
		wr(6'h08, 8'h02);
		settle();
		chk("wor_low", 32'h3, PS_PAD.oe);
		chk("wor_pull", 32'hD, PS_PAD.pull_en);
		wr(6'h08, 8'h03);
		settle();
		chk("wor_high", 32'h2, PS_PAD.oe);
		rc("wor_pin", 6'h09, 32'hF);
		wr(6'h0D, 8'h04);
		settle();
		chk("spol_dn", 32'h4, PS_PAD.pull_dn);
		rc("spol_pin", 6'h09, 32'hB);
	endtask : t_wor

	initial
	begin
		NRST = 1'b0;
		{HSEL, HWRITE, HADDR, HWDATA, HTRANS} = '0;
		HSIZE = 3'h2;
		{TIM_OUT_EN, TIM_OUT, PWM_EN, PWM_OUT} = '0;
		{SER_TX_EN, SER_RX_EN, SER_TXD, ext_en, ext_val} = '0;
		repeat (5) @(posedge CLK);
		NRST <= 1'b1;
		t_reset();
		t_tpull();
		t_route();
		t_sdata();
		t_serial();
		t_wor();
		summarize();
	end
endmodule : port_t_s_pin_control_test
